// ==== core/idt_decode.sv ====
// Purpose: Decode data-transfer opcodes and time their execution
// Assumes: Queue fed by the bus interface unit on clk_sys
// Notes:   One instruction in flight; busy holds for all but the first (take) clock of its count
`timescale 1ns/100ps
module idt_decode
  import idt_pkg::*;
#(
  parameter bit NARROW_BUS = 1'b0
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] q_byte0,
  input  wire logic [7:0] q_byte1,
  input  wire logic [2:0] q_count,
  input  wire logic       ea_odd,
  input  wire logic [1:0] hs_extra,
  input  wire logic       flush_req,
  input  wire logic       target_fetched,
  output logic            q_pop,
  output logic [1:0]      q_pop_n,
  output logic            busy,
  output logic [7:0]      cycles,
  output logic            word_op,
  output logic            mem_op,
  output logic            done
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_EXEC  = 3'b010,
    S_FETCH = 3'b100
  } idt_state_e;

  localparam logic [2:0] QMAX = NARROW_BUS ? 3'(QDEPTH_NARROW) : 3'(QDEPTH_WIDE);

  idt_state_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] cyc_r, cyc_nxt;
  logic       word_r, word_nxt, mem_r, mem_nxt, done_r, done_nxt;
  logic [7:0] base;
  logic [1:0] need;
  logic       is_mem, is_w, star, known, can_go;

  always_comb begin
    base  = CYC_OTHER;
    need  = 2'h1;
    star  = 1'b0;
    known = 1'b1;
    is_mem = q_byte1[7:6] != MOD_REG;
    is_w   = q_byte0[0];
    case (q_byte0)
      OP_MOV_RM_R, {OP_MOV_RM_R[7:1], 1'b1}: begin
        need = 2'h2;
        star = 1'b1;
        base = is_mem ? CYC_MOV_ST_M : CYC_REG2;
      end
      OP_MOV_R_RM, {OP_MOV_R_RM[7:1], 1'b1}: begin
        need = 2'h2;
        base = is_mem ? CYC_MOV_LD_M : CYC_REG2;
      end
      OP_MOV_RM_SR: begin
        need = 2'h2;
        is_w = 1'b1;
        base = !is_mem ? CYC_REG2 : (NARROW_BUS ? CYC_SRL_NAR : CYC_SRL_WIDE);
      end
      OP_MOV_SR_RM: begin
        need = 2'h2;
        is_w = 1'b1;
        base = !is_mem ? CYC_REG2 : (NARROW_BUS ? CYC_SRS_NAR : CYC_SRS_WIDE);
      end
      // Direct address forms always touch memory
      OP_MOV_ACC_LD, {OP_MOV_ACC_LD[7:1], 1'b1}: begin
        need   = 2'h3;
        star   = 1'b1;
        is_mem = 1'b1;
        base   = CYC_ACC_LD;
      end
      OP_MOV_ACC_ST, {OP_MOV_ACC_ST[7:1], 1'b1}: begin
        need   = 2'h3;
        star   = 1'b1;
        is_mem = 1'b1;
        base   = CYC_ACC_ST;
      end
      OP_PUSH_MEM: begin
        need = 2'h2;
        base = NARROW_BUS ? CYC_PUSH_N : CYC_PUSH_W;
      end
      OP_POP_MEM: begin
        need = 2'h2;
        base = NARROW_BUS ? CYC_POP_N : CYC_POP_W;
      end
      OP_PUSHA: begin
        is_mem = 1'b1;
        base = NARROW_BUS ? CYC_PUSHA_N : CYC_PUSHA_W;
      end
      default: begin
        known  = 1'b0;
        is_mem = 1'b0;
      end
    endcase
    if (NARROW_BUS && star && is_mem && is_w) begin
      base = base + CYC_WORD_ADD;
    end
    if (!NARROW_BUS && is_mem && is_w && ea_odd) begin
      base = base + CYC_MISALIGN;
    end
    if (is_mem) begin
      base = base + {6'h00, (hs_extra > CYC_HS_MAX[1:0]) ? CYC_HS_MAX[1:0] : hs_extra};
    end
  end

  assign can_go  = (q_count >= {1'b0, need}) && (q_count <= QMAX);
  assign q_pop   = (state_r == S_IDLE) && can_go && !flush_req;
  assign q_pop_n = q_pop ? need : 2'h0;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cyc_nxt   = cyc_r;
    word_nxt  = word_r;
    mem_nxt   = mem_r;
    done_nxt  = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (flush_req) begin
          state_nxt = S_FETCH;
        end else if (can_go) begin
          state_nxt = S_EXEC;
          cnt_nxt   = base - 8'h01;
          cyc_nxt   = base;
          word_nxt  = is_w && known;
          mem_nxt   = is_mem;
        end
      end
      S_EXEC: begin
        if (cnt_r <= 8'h01) begin
          state_nxt = S_IDLE;
          done_nxt  = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_FETCH: begin
        if (target_fetched) begin
          state_nxt = S_IDLE;
          done_nxt  = 1'b1;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      cnt_r   <= 8'h00;
      cyc_r   <= 8'h00;
      word_r  <= 1'b0;
      mem_r   <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cyc_r   <= cyc_nxt;
      word_r  <= word_nxt;
      mem_r   <= mem_nxt;
      done_r  <= done_nxt;
    end
  end

  assign busy    = state_r != S_IDLE;
  assign cycles  = cyc_r;
  assign word_op = word_r;
  assign mem_op  = mem_r;
  assign done    = done_r;

  AST_NO_POP_SHORT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q_pop |-> q_count >= {1'b0, q_pop_n})
    else $error("pop with too few queued bytes");
  AST_REG_TWO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_pop && q_byte0 == OP_MOV_RM_SR && q_byte1[7:6] == MOD_REG) |=> cycles == CYC_REG2)
    else $error("register segment load not two clocks");
  AST_SEG_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_pop && q_byte0 == OP_MOV_SR_RM && q_byte1[7:6] != MOD_REG && hs_extra == 2'h0
     && !ea_odd) |=> cycles == (NARROW_BUS ? CYC_SRS_NAR : CYC_SRS_WIDE))
    else $error("segment store memory count wrong");
  AST_SEG_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_pop && q_byte0 == OP_MOV_RM_SR && q_byte1[7:6] != MOD_REG && hs_extra == 2'h0
     && !ea_odd) |=> cycles == (NARROW_BUS ? CYC_SRL_NAR : CYC_SRL_WIDE))
    else $error("segment load memory count wrong");
  AST_WIDTH_BIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_pop && q_byte0[7:1] == OP_MOV_R_RM[7:1]) |=> word_op == $past(q_byte0[0]))
    else $error("operand width not from bit zero");
  AST_DONE_TIME: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_pop && q_byte0 == OP_MOV_RM_SR && q_byte1[7:6] == MOD_REG) |=> busy ##1 done)
    else $error("two clock instruction did not finish");
  AST_FETCH_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == S_FETCH && !target_fetched) |=> busy)
    else $error("left fetch before target byte");
  AST_HS_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_pop && q_byte0 == OP_PUSH_MEM && !ea_odd) |=>
      cycles <= (NARROW_BUS ? CYC_PUSH_N : CYC_PUSH_W) + CYC_HS_MAX)
    else $error("handshake extra beyond two clocks");
endmodule // idt_decode

// ==== core/idt_pkg.sv ====
// Purpose: Constants for the instruction decode and timing block
// Assumes: Opcode bytes arrive from the prefetch queue in order
// Notes:   Cycle figures are the fewest clocks of each form
package idt_pkg;
  localparam int QDEPTH_WIDE   = 6;
  localparam int QDEPTH_NARROW = 4;
  localparam logic [7:0] OP_MOV_RM_R   = 8'h88;
  localparam logic [7:0] OP_MOV_R_RM   = 8'h8a;
  localparam logic [7:0] OP_MOV_RM_SR  = 8'h8e;
  localparam logic [7:0] OP_MOV_SR_RM  = 8'h8c;
  localparam logic [7:0] OP_MOV_ACC_LD = 8'ha0;
  localparam logic [7:0] OP_MOV_ACC_ST = 8'ha2;
  localparam logic [7:0] OP_PUSH_MEM   = 8'hff;
  localparam logic [7:0] OP_POP_MEM    = 8'h8f;
  localparam logic [7:0] OP_PUSHA      = 8'h60;
  localparam logic [1:0] MOD_REG       = 2'h3;
  localparam logic [7:0] CYC_REG2      = 8'h02;
  localparam logic [7:0] CYC_MOV_ST_M  = 8'h0c;
  localparam logic [7:0] CYC_MOV_LD_M  = 8'h09;
  localparam logic [7:0] CYC_SRL_WIDE  = 8'h09;
  localparam logic [7:0] CYC_SRL_NAR   = 8'h0d;
  localparam logic [7:0] CYC_SRS_WIDE  = 8'h0b;
  localparam logic [7:0] CYC_SRS_NAR   = 8'h0f;
  localparam logic [7:0] CYC_ACC_LD    = 8'h08;
  localparam logic [7:0] CYC_ACC_ST    = 8'h09;
  localparam logic [7:0] CYC_PUSH_W    = 8'h10;
  localparam logic [7:0] CYC_PUSH_N    = 8'h14;
  localparam logic [7:0] CYC_POP_W     = 8'h14;
  localparam logic [7:0] CYC_POP_N     = 8'h18;
  localparam logic [7:0] CYC_PUSHA_W   = 8'h24;
  localparam logic [7:0] CYC_PUSHA_N   = 8'h44;
  localparam logic [7:0] CYC_OTHER     = 8'h02;
  localparam logic [7:0] CYC_WORD_ADD  = 8'h04;
  localparam logic [7:0] CYC_MISALIGN  = 8'h04;
  localparam logic [7:0] CYC_HS_MAX    = 8'h02;
endpackage

// ==== tb/idt_queue_model.sv ====
// Purpose: Prefetch queue filler on the far side of the decoder
// Assumes: Changes land on the falling edge of clk_sys
// Notes:   Empty slots show inverted bytes, never stale ones
`timescale 1ns/100ps
module idt_queue_model #(
  parameter int DEPTH = 6
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [15:0] ins,
  input  wire logic        fill,
  input  wire logic        q_pop,
  input  wire logic [1:0]  q_pop_n,
  output logic [7:0]       q_byte0,
  output logic [7:0]       q_byte1,
  output logic [2:0]       q_count
);
  logic       tk_r;
  logic [1:0] tn_r;
  logic       fl_r;
  // Fill taken on the rising edge, clear of the bench's falling-edge writes
  always @(posedge clk_sys) begin
    tk_r <= q_pop;
    tn_r <= q_pop_n;
    fl_r <= fill;
  end
  always @(negedge clk_sys) begin
    if (!rst_n) begin
      q_count <= 3'h0;
    end else begin
      q_count <= q_count - (tk_r ? tn_r : 2'h0) + ((fl_r && q_count < DEPTH) ? 3'h1 : 3'h0);
    end
  end
  assign q_byte0 = (q_count > 3'h0) ? ins[15:8] : ~ins[15:8];
  assign q_byte1 = (q_count > 3'h1) ? ins[7:0] : ~ins[7:0];
endmodule // idt_queue_model

// ==== tb/instruction_decode_timing_tb.sv ====
// Purpose: Self-checking bench for the decode and timing block
// Assumes: Wide bus build, inputs change on the falling edge
// Notes:   Elapsed count runs from the take edge to done
`timescale 1ns/100ps
module instruction_decode_timing_tb;
  import idt_pkg::*;
  logic        clk_sys, rst_n, ea_odd, flush_req, target_fetched, fill;
  logic        q_pop, busy, word_op, mem_op, done;
  logic [1:0]  hs_extra, q_pop_n;
  logic [2:0]  q_count;
  logic [7:0]  q_byte0, q_byte1, cycles;
  logic [15:0] ins;
  int          miscompares, compares;
  idt_decode dut (.clk_sys(clk_sys), .rst_n(rst_n), .q_byte0(q_byte0), .q_byte1(q_byte1),
    .q_count(q_count), .ea_odd(ea_odd), .hs_extra(hs_extra), .flush_req(flush_req),
    .target_fetched(target_fetched), .q_pop(q_pop), .q_pop_n(q_pop_n), .busy(busy),
    .cycles(cycles), .word_op(word_op), .mem_op(mem_op), .done(done));
  idt_queue_model #(.DEPTH(QDEPTH_WIDE)) queue (.clk_sys(clk_sys), .rst_n(rst_n), .ins(ins),
    .fill(fill), .q_pop(q_pop), .q_pop_n(q_pop_n), .q_byte0(q_byte0), .q_byte1(q_byte1),
    .q_count(q_count));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick_or_quit(inout int n, input int lim);
    @(negedge clk_sys);
    n++;
    if (n > lim) begin
      miscompares++;
      wrap_up();
    end
  endtask
  // Short queue must hold the take back
  task automatic stall();
    repeat (3) @(negedge clk_sys);
    cmp("q_pop", 8'h0, {7'h0, q_pop});
    fill = 1'b1;
    @(negedge clk_sys);
    #1;
    cmp("q_pop", 8'h0, {7'h0, q_pop});
  endtask
  task automatic run(input logic [15:0] i, input logic odd, input logic [1:0] hs,
                     input logic [7:0] exp, input logic mem);
    int n;
    n = 0;
    ins = i;
    ea_odd = odd;
    hs_extra = hs;
    #1;
    while (q_pop !== 1'b1) begin
      tick_or_quit(n, 20);
      #1;
    end
    cmp("q_pop_n", 8'h2, {6'h0, q_pop_n});
    n = 0;
    // Step past the take edge; done may still show the previous pulse
    tick_or_quit(n, 200);
    while (done !== 1'b1) begin
      tick_or_quit(n, 200);
    end
    cmp("cycles", exp, cycles);
    cmp("elapsed", exp, n[7:0]);
    cmp("mem_op", {7'h0, mem}, {7'h0, mem_op});
  endtask
  task automatic flush();
    int n;
    n = 0;
    flush_req = 1'b1;
    @(negedge clk_sys);
    flush_req = 1'b0;
    cmp("busy", 8'h1, {7'h0, busy});
    repeat (3) @(negedge clk_sys);
    cmp("done", 8'h0, {7'h0, done});
    target_fetched = 1'b1;
    while (done !== 1'b1) begin
      tick_or_quit(n, 3);
    end
    target_fetched = 1'b0;
  endtask
  initial begin
    miscompares = 0;
    compares = 0;
    rst_n = 1'b0;
    ins = 16'h8e07;
    fill = 1'b0;
    ea_odd = 1'b0;
    hs_extra = 2'h0;
    flush_req = 1'b0;
    target_fetched = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    stall();
    run(16'h8e07, 1'b0, 2'h0, 8'h09, 1'b1);
    run(16'h8ec0, 1'b0, 2'h0, 8'h02, 1'b0);
    run(16'h8c07, 1'b0, 2'h0, 8'h0b, 1'b1);
    run(16'h8cc3, 1'b0, 2'h0, 8'h02, 1'b0);
    run(16'h8907, 1'b1, 2'h0, 8'h10, 1'b1);
    cmp("word_op", 8'h1, {7'h0, word_op});
    run(16'h8807, 1'b1, 2'h0, 8'h0c, 1'b1);
    cmp("word_op", 8'h0, {7'h0, word_op});
    run(16'h8e07, 1'b0, 2'h2, 8'h0b, 1'b1);
    run(16'hff36, 1'b0, 2'h1, 8'h11, 1'b1);
    flush();
    wrap_up();
  end
endmodule // instruction_decode_timing_tb
